//--- verilog/gpa_pkg.sv
package gpa_pkg;
  localparam int unsigned XLEN          = 64;
  localparam int unsigned GPR_COUNT     = 16;
  localparam int unsigned DISP_BITS     = 32;
  localparam int unsigned LEGACY_BITS   = 32;
  localparam int unsigned PAE_PHYS_BITS = 36;
  localparam int unsigned VA_BITS_DEF   = 48;
  localparam int unsigned LANES         = 8;

  // operand and address sizes
  typedef enum logic [1:0] {SZ8 = 2'h0, SZ16 = 2'h1, SZ32 = 2'h2, SZ64 = 2'h3} gpa_size_type;
  // segment selects as the decoder presents them
  typedef enum logic [2:0] {
    SEG_EXTRA = 3'h0, SEG_CODE = 3'h1, SEG_STACK = 3'h2,
    SEG_DATA = 3'h3, SEG_XD1 = 3'h4, SEG_XD2 = 3'h5
  } gpa_seg_type;
  // fault outcome of an address request
  typedef enum logic [2:0] {
    FLT_NONE = 3'h0, FLT_PRIV = 3'h1, FLT_GP = 3'h2,
    FLT_SS = 3'h3, FLT_PAGE = 3'h4, FLT_ALIGN = 3'h5
  } gpa_fault_type;

  localparam logic [3:0] IDX_SP = 4'h4;
  localparam logic [3:0] IDX_BP = 4'h5;
  localparam logic [7:0] LANE_LO  = 8'h01;
  localparam logic [7:0] LANE_HI  = 8'h02;
  localparam logic [7:0] LANE_W   = 8'h03;
  localparam logic [7:0] LANE_ALL = 8'hFF;
  localparam logic [XLEN-1:0] RESET_WORD = 64'h0;
endpackage

//--- verilog/gpa_core.sv
`timescale 1ns/1ps
module gpa_core
  import gpa_pkg::*;
#(
  parameter int unsigned VA_BITS = VA_BITS_DEF
) (
  input  wire logic            clock_i,
  input  wire logic            rst_n_i,
  input  wire logic            ce_i,
  input  wire logic            mode64_i,
  input  wire logic            wr_en_i,
  input  wire logic [3:0]      wr_enc_i,
  input  wire logic [1:0]      wr_size_i,
  input  wire logic            wr_rex_i,
  input  wire logic [XLEN-1:0] wr_data_i,
  input  wire logic [3:0]      rd_enc_i,
  input  wire logic [1:0]      rd_size_i,
  input  wire logic            rd_rex_i,
  input  wire logic            ip_wr_i,
  input  wire logic [1:0]      ip_size_i,
  input  wire logic [XLEN-1:0] ip_next_i,
  input  wire logic            agu_req_i,
  input  wire logic            base_valid_i,
  input  wire logic [3:0]      base_idx_i,
  input  wire logic            index_valid_i,
  input  wire logic [3:0]      index_idx_i,
  input  wire logic [1:0]      scale_i,
  input  wire logic [XLEN-1:0] disp_i,
  input  wire logic            disp64_form_i,
  input  wire logic [1:0]      addr_size_i,
  input  wire logic [2:0]      seg_i,
  input  wire logic [XLEN-1:0] seg_base_i,
  input  wire logic            stack_ref_i,
  input  wire logic            priv_fault_i,
  input  wire logic            page_fault_i,
  input  wire logic            align_fault_i,
  output logic [XLEN-1:0]      rd_data_o,
  output logic [XLEN-1:0]      ip_o,
  output logic                 agu_valid_o,
  output logic [XLEN-1:0]      lin_addr_o,
  output logic [2:0]           fault_o
);

  typedef struct packed {
    logic [GPR_COUNT-1:0][XLEN-1:0] gpr;
    logic [XLEN-1:0]                ip;
    logic [XLEN-1:0]                rd_data;
    logic                           agu_valid;
    logic [XLEN-1:0]                lin_addr;
    gpa_fault_type                  fault;
  } gpa_state_type;

  gpa_state_type state_reg;
  gpa_state_type state_next;

  // operand size the prefix allows; qword needs the extension prefix
  function automatic gpa_size_type eff_size(input logic [1:0] sz, input logic register_extension_prefix);
    gpa_size_type s;
    s = gpa_size_type'(sz);
    if (s == SZ64 && !register_extension_prefix) begin
      s = SZ32;
    end
    return s;
  endfunction

  // register view decode: {high byte, register index}
  function automatic logic [4:0] view_sel(input logic [3:0] enc, input logic [1:0] sz,
                                          input logic register_extension_prefix);
    logic [3:0] idx;
    logic       hi;
    idx = register_extension_prefix ? enc : {1'b0, enc[2:0]};
    hi  = 1'b0;
    // legacy high-byte encodings only exist without the prefix
    if (gpa_size_type'(sz) == SZ8 && !register_extension_prefix && enc[2]) begin
      idx = {2'b00, enc[1:0]};
      hi  = 1'b1;
    end
    return {hi, idx};
  endfunction

  // all bits from the top down to the top implemented bit agree
  function automatic logic canonical(input logic [XLEN-1:0] a);
    return (&a[XLEN-1:VA_BITS-1]) | ~(|a[XLEN-1:VA_BITS-1]);
  endfunction

  logic [4:0]                     wr_sel;
  gpa_size_type                   wr_sz;
  logic [7:0]                     wr_lanes;
  logic [XLEN-1:0]                wr_word;
  logic [GPR_COUNT-1:0][XLEN-1:0] gpr_wr_val;
  logic [XLEN-1:0]                sel_word;

  // write view decode and lane placement
  always_comb begin
    wr_sel = view_sel(wr_enc_i, wr_size_i, wr_rex_i);
    wr_sz  = eff_size(wr_size_i, wr_rex_i);
    case (wr_sz)
      SZ8: begin
        wr_lanes = wr_sel[4] ? LANE_HI : LANE_LO;
        wr_word  = wr_sel[4] ? {48'h0, wr_data_i[7:0], 8'h00} : {56'h0, wr_data_i[7:0]};
      end
      SZ16: begin
        wr_lanes = LANE_W;
        wr_word  = {48'h0, wr_data_i[15:0]};
      end
      SZ32: begin
        // zero-extended also outside 64-bit mode; upper half is undefined there
        wr_lanes = LANE_ALL;
        wr_word  = {32'h0, wr_data_i[31:0]};
      end
      default: begin
        wr_lanes = LANE_ALL;
        wr_word  = wr_data_i;
      end
    endcase
  end

  // old contents of the addressed register; the lane checks compare against it
  assign sel_word = state_reg.gpr[wr_sel[3:0]];

  // per-register byte-lane merge, untouched lanes hold their bytes
  for (genvar g = 0; g < GPR_COUNT; g++) begin : gpr_lane
    logic hit;
    assign hit = wr_en_i && (wr_sel[3:0] == 4'(g));
    for (genvar b = 0; b < LANES; b++) begin : lane
      assign gpr_wr_val[g][b*8 +: 8] = (hit && wr_lanes[b]) ? wr_word[b*8 +: 8]
                                                           : state_reg.gpr[g][b*8 +: 8];
    end
  end

  logic [4:0]      rd_sel;
  logic [XLEN-1:0] rd_raw;
  logic [XLEN-1:0] rd_view;

  // read views, zero-extended onto the result bus
  always_comb begin
    rd_sel = view_sel(rd_enc_i, rd_size_i, rd_rex_i);
    rd_raw = state_reg.gpr[rd_sel[3:0]];
    case (eff_size(rd_size_i, rd_rex_i))
      SZ8:     rd_view = rd_sel[4] ? {56'h0, rd_raw[15:8]} : {56'h0, rd_raw[7:0]};
      SZ16:    rd_view = {48'h0, rd_raw[15:0]};
      SZ32:    rd_view = {32'h0, rd_raw[31:0]};
      default: rd_view = rd_raw;
    endcase
  end

  logic [XLEN-1:0] base_val;
  logic [XLEN-1:0] index_val;
  logic [XLEN-1:0] disp_ext;
  logic [XLEN-1:0] ea_sum;
  logic [XLEN-1:0] ea_trunc;
  logic [XLEN-1:0] seg_eff;
  logic [XLEN-1:0] lin_full;
  logic [XLEN-1:0] lin;
  logic            xd_seg;
  logic            stack_kind;
  gpa_fault_type   fault_sel;

  // address generation; sum, truncate, then add the untruncated base
  always_comb begin
    base_val  = base_valid_i ? state_reg.gpr[base_idx_i] : RESET_WORD;
    index_val = index_valid_i ? state_reg.gpr[index_idx_i] : RESET_WORD;
    if (disp64_form_i && mode64_i) begin
      disp_ext = disp_i;
    end else begin
      disp_ext = {{(XLEN-DISP_BITS){disp_i[DISP_BITS-1]}}, disp_i[DISP_BITS-1:0]};
    end
    ea_sum = base_val + (index_val << scale_i) + disp_ext;
    case (gpa_size_type'(addr_size_i))
      SZ16:    ea_trunc = {48'h0, ea_sum[15:0]};
      SZ32:    ea_trunc = {32'h0, ea_sum[31:0]};
      default: ea_trunc = ea_sum;
    endcase
    xd_seg  = (seg_i == SEG_XD1) || (seg_i == SEG_XD2);
    // only the two extra data segments keep a base in 64-bit mode
    seg_eff  = (mode64_i && !xd_seg) ? RESET_WORD : seg_base_i;
    lin_full = ea_trunc + seg_eff;
    // legacy modes wrap inside a 4 GByte linear space, cut to LEGACY_BITS
    lin = mode64_i ? lin_full : {32'h0, lin_full[LEGACY_BITS-1:0]};
    // an override to a non-stack segment arrives as seg_i, so it lands on GP
    stack_kind = stack_ref_i ||
                 (base_valid_i && (base_idx_i == IDX_SP || base_idx_i == IDX_BP) &&
                  seg_i == SEG_STACK);
    // privilege first, canonical next, paging and alignment last
    if (priv_fault_i) begin
      fault_sel = FLT_PRIV;
    end else if (mode64_i && !canonical(lin)) begin
      fault_sel = stack_kind ? FLT_SS : FLT_GP;
    end else if (page_fault_i) begin
      fault_sel = FLT_PAGE;
    end else if (align_fault_i) begin
      fault_sel = FLT_ALIGN;
    end else begin
      fault_sel = FLT_NONE;
    end
  end

  // next state; clock enable low holds everything
  always_comb begin
    state_next = state_reg;
    if (ce_i) begin
      state_next.gpr     = gpr_wr_val;
      state_next.rd_data = rd_view;
      if (ip_wr_i) begin
        case (gpa_size_type'(ip_size_i))
          SZ16:    state_next.ip = {state_reg.ip[63:16], ip_next_i[15:0]};
          SZ32:    state_next.ip = {32'h0, ip_next_i[31:0]};
          default: state_next.ip = ip_next_i;
        endcase
      end
      state_next.agu_valid = agu_req_i;
      if (agu_req_i) begin
        state_next.lin_addr = lin;
        state_next.fault    = fault_sel;
      end
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs come straight from the state register, no logic after the flops
  assign rd_data_o   = state_reg.rd_data;
  assign ip_o        = state_reg.ip;
  assign agu_valid_o = state_reg.agu_valid;
  assign lin_addr_o  = state_reg.lin_addr;
  assign fault_o     = state_reg.fault;

  // assertions share the core clock; reset masks them
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // narrow pointer update keeps the upper bits
  ip_narrow_a: assert property ($past(rst_n_i && ce_i && ip_wr_i && ip_size_i == SZ16) |->
      ip_o[63:16] == $past(ip_o[63:16]) && ip_o[15:0] == $past(ip_next_i[15:0]))
    else $error("narrow pointer write disturbed upper bits");

  // mid pointer update clears the upper half
  ip_mid_a: assert property ($past(rst_n_i && ce_i && ip_wr_i && ip_size_i == SZ32) |->
      ip_o == {32'h0, $past(ip_next_i[31:0])})
    else $error("mid pointer write not zero-extended");

  // wide pointer update takes every bit
  ip_full_a: assert property ($past(rst_n_i && ce_i && ip_wr_i && ip_size_i == SZ64) |->
      ip_o == $past(ip_next_i))
    else $error("wide pointer write lost bits");

  // dword write zero-extends
  wr_dword_a: assert property ($past(rst_n_i && ce_i && wr_en_i && wr_sz == SZ32) |->
      state_reg.gpr[$past(wr_sel[3:0])][63:32] == 32'h0)
    else $error("dword write left upper half set");

  // qword write fills the register
  qword_full_a: assert property ($past(rst_n_i && ce_i && wr_en_i && wr_sz == SZ64) |->
      state_reg.gpr[$past(wr_sel[3:0])] == $past(wr_data_i))
    else $error("qword write lost bits");

  // low byte write keeps the upper seven bytes
  wr_byte_a: assert property ($past(rst_n_i && ce_i && wr_en_i && wr_sz == SZ8 && !wr_sel[4])
      |-> state_reg.gpr[$past(wr_sel[3:0])][63:8] == $past(sel_word[63:8]))
    else $error("byte write touched upper bytes");

  // word write keeps the upper six bytes
  word_keep_a: assert property ($past(rst_n_i && ce_i && wr_en_i && wr_sz == SZ16) |->
      state_reg.gpr[$past(wr_sel[3:0])][63:16] == $past(sel_word[63:16]))
    else $error("word write touched upper bytes");

  // the prefix remaps high-byte encodings to low bytes
  hibyte_rex_a: assert property (wr_en_i && wr_size_i == SZ8 && wr_rex_i |->
      !wr_sel[4] && wr_sel[3:0] == wr_enc_i)
    else $error("high byte selected under extension prefix");

  // no prefix, no extended registers and no qword
  ext_reg_a: assert property (wr_en_i && !wr_rex_i |->
      !wr_sel[3] && wr_sz != SZ64)
    else $error("extended access without prefix");

  // legacy high-byte read shows byte 1 of the first four registers
  hibyte_read_a: assert property ($past(rst_n_i && ce_i && rd_size_i == SZ8 && !rd_rex_i &&
      rd_enc_i[2]) |-> rd_data_o == {56'h0, $past(state_reg.gpr[{2'b00, rd_enc_i[1:0]}][15:8])})
    else $error("high byte view read wrong byte");

  // short displacements are sign-extended
  disp_sext_a: assert property (!(disp64_form_i && mode64_i) |->
      disp_ext[63:32] == {32{disp_i[31]}})
    else $error("short displacement not sign-extended");

  // a 32-bit address stays in the low 4 GBytes unless an extra data segment base is added
  ea_trunc_a: assert property ($past(rst_n_i && ce_i && agu_req_i && addr_size_i == SZ32 &&
      seg_i != SEG_XD1 && seg_i != SEG_XD2) |-> agu_valid_o && lin_addr_o[63:32] == 32'h0)
    else $error("32-bit address escaped low 4 GBytes");

  // flat segments leave the effective address as is
  seg_flat_a: assert property ($past(rst_n_i && ce_i && agu_req_i && mode64_i && !xd_seg) |->
      lin_addr_o == $past(ea_trunc))
    else $error("flat segment base was added");

  // legacy linear space is cut to 32 bits
  legacy_cut_a: assert property ($past(rst_n_i && ce_i && agu_req_i && !mode64_i) |->
      lin_addr_o[63:32] == 32'h0)
    else $error("legacy linear address above 4 GBytes");

  // a clean 64-bit result is canonical
  canon_a: assert property (agu_valid_o && $past(mode64_i) && fault_o == FLT_NONE |->
      canonical(lin_addr_o))
    else $error("non-canonical address passed without fault");

  // canonical faults exist only in 64-bit mode
  legacy_canon_a: assert property ($past(rst_n_i && ce_i && agu_req_i && !mode64_i) |->
      fault_o != FLT_GP && fault_o != FLT_SS)
    else $error("canonical fault outside 64-bit mode");

  // privilege ranks above everything
  fault_order_a: assert property ($past(rst_n_i && ce_i && agu_req_i && priv_fault_i) |->
      fault_o == FLT_PRIV)
    else $error("privilege fault not ranked first");

  // paging only loses to privilege and canonical faults
  page_after_a: assert property ($past(rst_n_i && ce_i && agu_req_i && !priv_fault_i &&
      page_fault_i) |-> fault_o == FLT_PAGE || fault_o == FLT_GP || fault_o == FLT_SS)
    else $error("page fault ranked wrongly");

  // stack fault needs a stack reference or stack segment
  stack_fault_a: assert property (agu_valid_o && fault_o == FLT_SS |->
      $past(stack_ref_i || seg_i == SEG_STACK))
    else $error("stack fault without stack segment");

  // every request with clock enable high is answered one cycle later, exactly
  agu_valid_a: assert property ($past(rst_n_i && ce_i) |->
      agu_valid_o == $past(agu_req_i))
    else $error("address answer not one cycle after request");

  // clock enable low freezes the pointer, linear address and read data outputs
  ce_hold_a: assert property ($past(rst_n_i && !ce_i) |-> ip_o == $past(ip_o) &&
      lin_addr_o == $past(lin_addr_o) && rd_data_o == $past(rd_data_o))
    else $error("state moved with clock enable low");

endmodule // gpa_core

//--- dv/gpa_pipe_model.sv
`timescale 1ns/1ps
// decoder and pipeline side: one request per task, driven just after a rising edge
module gpa_pipe_model
  import gpa_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic [XLEN-1:0] rd_data_o,
  input  wire logic [XLEN-1:0] ip_o,
  input  wire logic            agu_valid_o,
  input  wire logic [XLEN-1:0] lin_addr_o,
  input  wire logic [2:0]      fault_o,
  output logic ce_i, mode64_i, wr_en_i, wr_rex_i, rd_rex_i, ip_wr_i, agu_req_i,
  output logic base_valid_i, index_valid_i, disp64_form_i, stack_ref_i,
  output logic priv_fault_i, page_fault_i, align_fault_i,
  output logic [3:0] wr_enc_i, rd_enc_i, base_idx_i, index_idx_i,
  output logic [1:0] wr_size_i, rd_size_i, ip_size_i, scale_i, addr_size_i,
  output logic [2:0] seg_i,
  output logic [XLEN-1:0] wr_data_i, ip_next_i, disp_i, seg_base_i
);
  // idle values at time zero; core starts in 64-bit mode with the clock enabled
  initial begin
    {ce_i, mode64_i, wr_en_i, wr_rex_i, rd_rex_i, ip_wr_i, agu_req_i} = 7'h60;
    {base_valid_i, index_valid_i, disp64_form_i, stack_ref_i} = 4'hC;
    {priv_fault_i, page_fault_i, align_fault_i, wr_enc_i, rd_enc_i} = 11'h0;
    {base_idx_i, index_idx_i, wr_size_i, rd_size_i, ip_size_i, scale_i, addr_size_i} = 18'h0;
    {seg_i, wr_data_i, ip_next_i, disp_i, seg_base_i} = 259'h0;
  end

  // released data turns to its inverse so a stale value can never pass for a good one
  task automatic wr(input logic [3:0] enc, input logic [1:0] sz, input logic register_extension_prefix,
                    input logic [XLEN-1:0] data);
    @(posedge clock_i);
    {wr_en_i, wr_enc_i, wr_size_i, wr_rex_i, wr_data_i} <= {1'b1, enc, sz, register_extension_prefix, data};
    @(posedge clock_i);
    {wr_en_i, wr_data_i} <= {1'b0, ~data};
  endtask

  task automatic set_mode(input logic m, input logic c);
    @(posedge clock_i);
    {mode64_i, ce_i} <= {m, c};
  endtask

  task automatic rd(input logic [3:0] enc, input logic [1:0] sz, input logic register_extension_prefix,
                    output logic [XLEN-1:0] q);
    @(posedge clock_i);
    {rd_enc_i, rd_size_i, rd_rex_i} <= {enc, sz, register_extension_prefix};
    @(posedge clock_i);
    #1 q = rd_data_o;
  endtask

  task automatic ipw(input logic [1:0] sz, input logic [XLEN-1:0] nxt,
                     output logic [XLEN-1:0] q);
    @(posedge clock_i);
    {ip_wr_i, ip_size_i, ip_next_i} <= {1'b1, sz, nxt};
    @(posedge clock_i);
    {ip_wr_i, ip_next_i} <= {1'b0, ~nxt};
    #1 q = ip_o;
  endtask

  // index is always register 7 scaled by four; flt is {stack, priv, page, align}
  task automatic agu(input logic [3:0] bidx, input logic [XLEN-1:0] disp, input logic d64,
                     input logic [1:0] asz, input logic [2:0] seg, input logic [XLEN-1:0] sb,
                     input logic [3:0] flt, output logic [XLEN-1:0] lin,
                     output logic [3:0] res);
    @(posedge clock_i);
    {agu_req_i, base_idx_i, index_idx_i, scale_i} <= {1'b1, bidx, 4'h7, 2'h2};
    {disp_i, disp64_form_i, addr_size_i, seg_i, seg_base_i} <= {disp, d64, asz, seg, sb};
    {stack_ref_i, priv_fault_i, page_fault_i, align_fault_i} <= flt;
    @(posedge clock_i);
    {agu_req_i, disp_i, seg_base_i} <= {1'b0, ~disp, ~sb};
    #1 lin = lin_addr_o;
    res = {agu_valid_o, fault_o};
  endtask
endmodule // gpa_pipe_model

//--- dv/gpa_core_bench.sv
`timescale 1ns/1ps
module gpa_core_bench
  import gpa_pkg::*;
;
  logic clock_i, rst_n_i, agu_valid_o;
  logic ce_i, mode64_i, wr_en_i, wr_rex_i, rd_rex_i, ip_wr_i, agu_req_i;
  logic base_valid_i, index_valid_i, disp64_form_i, stack_ref_i;
  logic priv_fault_i, page_fault_i, align_fault_i;
  logic [3:0] wr_enc_i, rd_enc_i, base_idx_i, index_idx_i, r;
  logic [1:0] wr_size_i, rd_size_i, ip_size_i, scale_i, addr_size_i;
  logic [2:0] seg_i, fault_o;
  logic [XLEN-1:0] wr_data_i, ip_next_i, disp_i, seg_base_i, rd_data_o, ip_o, lin_addr_o, q;
  int bad_count;
  int checks_done;

  gpa_core i_dut (.*);
  gpa_pipe_model i_pipe (.*);

  task automatic chk(input string what, input logic [XLEN-1:0] exp, input logic [XLEN-1:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic rc(input logic [3:0] e, input logic [1:0] s, input logic x,
                    input logic [XLEN-1:0] exp);
    i_pipe.rd(e, s, x, q);
    chk("read view", exp, q);
  endtask

  // aliasing views, prefix remap and destination write widths
  task automatic test_views();
    i_pipe.wr(4'h0, SZ64, 1'b1, 64'h1122_3344_5566_7788);
    i_pipe.wr(4'h4, SZ8, 1'b0, 64'hFFFF_FFFF_FFFF_FFAB);
    rc(4'h0, SZ64, 1'b1, 64'h1122_3344_5566_AB88);
    rc(4'h4, SZ8, 1'b0, 64'h0000_0000_0000_00AB);
    rc(4'h0, SZ16, 1'b0, 64'h0000_0000_0000_AB88);
    i_pipe.wr(4'h4, SZ64, 1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
    i_pipe.wr(4'h4, SZ8, 1'b1, 64'h0000_0000_0000_00CD);
    rc(4'h4, SZ64, 1'b1, 64'hFFFF_FFFF_FFFF_FFCD);
    rc(4'h4, SZ8, 1'b0, 64'h0000_0000_0000_00AB);
    i_pipe.wr(4'h1, SZ64, 1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
    i_pipe.wr(4'h1, SZ16, 1'b0, 64'h0000_0000_0000_BEEF);
    rc(4'h1, SZ64, 1'b1, 64'hFFFF_FFFF_FFFF_BEEF);
    i_pipe.wr(4'h2, SZ32, 1'b0, 64'hFFFF_FFFF_1234_5678);
    rc(4'h2, SZ64, 1'b1, 64'h0000_0000_1234_5678);
    i_pipe.wr(4'h3, SZ64, 1'b0, 64'hFFFF_FFFF_8765_4321);
    rc(4'h3, SZ64, 1'b1, 64'h0000_0000_8765_4321);
    // without the prefix the extension bit is dropped, so register 15 stays untouched
    i_pipe.wr(4'hF, SZ64, 1'b1, 64'hA5A5_A5A5_A5A5_A5A5);
    i_pipe.wr(4'hF, SZ32, 1'b0, 64'h0000_0000_0000_0001);
    rc(4'hF, SZ64, 1'b1, 64'hA5A5_A5A5_A5A5_A5A5);
    rc(4'h7, SZ64, 1'b1, 64'h0000_0000_0000_0001);
  endtask

  task automatic test_ip();
    chk("ip after reset", 64'h0, ip_o);
    i_pipe.ipw(SZ64, 64'hAAAA_BBBB_CCCC_DDDD, q);
    chk("ip64", 64'hAAAA_BBBB_CCCC_DDDD, q);
    i_pipe.ipw(SZ16, 64'h5555_5555_5555_1234, q);
    chk("ip16", 64'hAAAA_BBBB_CCCC_1234, q);
    i_pipe.ipw(SZ32, 64'hFFFF_FFFF_8765_4321, q);
    chk("ip32", 64'h0000_0000_8765_4321, q);
  endtask

  task automatic ac(input logic [3:0] b, input logic [XLEN-1:0] d, input logic d64,
                    input logic [1:0] asz, input logic [2:0] sg, input logic [XLEN-1:0] sb,
                    input logic [3:0] flt, input logic [XLEN-1:0] el, input logic [2:0] ef);
    i_pipe.agu(b, d, d64, asz, sg, sb, flt, q, r);
    chk("linear address", el, q);
    chk("valid and fault", {60'h0, 1'b1, ef}, {60'h0, r});
  endtask

  // base register 6 or 5 plus register 7 times four plus displacement
  task automatic test_agu();
    i_pipe.wr(4'h6, SZ64, 1'b1, 64'h0000_1000_0000_0000);
    i_pipe.wr(4'h5, SZ64, 1'b1, 64'h0000_1000_0000_0000);
    i_pipe.wr(4'h7, SZ64, 1'b1, 64'h0000_0000_0000_0010);
    ac(4'h6, 64'h1234_5678_FFFF_FFE0, 1'b0, SZ64, SEG_DATA, 64'h5000, 4'h0,
       64'h0000_1000_0000_0020, FLT_NONE);
    ac(4'h6, 64'h1234_5678_FFFF_FFE0, 1'b0, SZ64, SEG_XD2, 64'hFFFF_8000_0000_0000, 4'h0,
       64'hFFFF_9000_0000_0020, FLT_NONE);
    ac(4'h6, 64'h0000_0000_0001_0000, 1'b0, SZ32, SEG_XD1, 64'h0000_0001_0000_0000, 4'h0,
       64'h0000_0001_0001_0040, FLT_NONE);
    ac(4'h6, 64'h0000_0000_0001_0000, 1'b0, SZ16, SEG_DATA, 64'h0, 4'h0,
       64'h0000_0000_0000_0040, FLT_NONE);
    ac(4'h6, 64'h0000_2000_0000_0000, 1'b1, SZ64, SEG_DATA, 64'h0, 4'h3,
       64'h0000_3000_0000_0040, FLT_PAGE);
    ac(4'h6, 64'hFFFF_7000_0000_0000, 1'b1, SZ64, SEG_DATA, 64'h0, 4'h0,
       64'hFFFF_8000_0000_0040, FLT_NONE);
    ac(4'h6, 64'h0000_8000_0000_0000, 1'b1, SZ64, SEG_DATA, 64'h0, 4'h0,
       64'h0000_9000_0000_0040, FLT_GP);
    ac(4'h6, 64'h0000_8000_0000_0000, 1'b1, SZ64, SEG_DATA, 64'h0, 4'h8,
       64'h0000_9000_0000_0040, FLT_SS);
    ac(4'h5, 64'h0000_8000_0000_0000, 1'b1, SZ64, SEG_STACK, 64'h0, 4'h0,
       64'h0000_9000_0000_0040, FLT_SS);
    ac(4'h5, 64'h0000_8000_0000_0000, 1'b1, SZ64, SEG_DATA, 64'h0, 4'h0,
       64'h0000_9000_0000_0040, FLT_GP);
    ac(4'h6, 64'h0000_8000_0000_0000, 1'b1, SZ64, SEG_DATA, 64'h0, 4'h4,
       64'h0000_9000_0000_0040, FLT_PRIV);
    ac(4'h6, 64'h0000_8000_0000_0000, 1'b1, SZ64, SEG_DATA, 64'h0, 4'h3,
       64'h0000_9000_0000_0040, FLT_GP);
  endtask

  // legacy linear space, then a frozen clock enable
  task automatic test_legacy();
    i_pipe.set_mode(1'b0, 1'b1);
    ac(4'h6, 64'hFFFF_FFFF_0000_0100, 1'b1, SZ64, SEG_DATA, 64'h0000_0000_F000_0000, 4'h0,
       64'h0000_0000_F000_0140, FLT_NONE);
    i_pipe.set_mode(1'b1, 1'b0);
    i_pipe.ipw(SZ64, 64'h1111_2222_3333_4444, q);
    chk("ip frozen", 64'h0000_0000_8765_4321, q);
    i_pipe.set_mode(1'b1, 1'b1);
  endtask

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  initial begin
    rst_n_i = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    test_ip();
    test_views();
    test_agu();
    test_legacy();
    end_sim();
  end

  // the whole run is under a hundred cycles; this catches a hung handshake
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
endmodule // gpa_core_bench
